//--- pkg/ccd_pkg.sv
package ccd_pkg;

  // Register offsets on the serial configuration port
  localparam logic [6:0] OFS_IFACE_CLK_CTRL = 7'h01;
  localparam logic [6:0] OFS_TX_LATCH_INTERP = 7'h13;
  localparam logic [6:0] OFS_PLL_RX_CFG      = 7'h15;
  localparam logic [6:0] OFS_AUX_SRC_SEL     = 7'h16;

  // interface_clock_output_control fields
  localparam int CLK_MODE_LSB      = 5;
  localparam int AUX_EN_BIT        = 2;
  localparam int DATA_INV_BIT      = 1;
  // transmit_latch_and_interpolation fields
  localparam int TX_EDGE_BIT       = 5;
  localparam int INTERP_LSB        = 0;
  // pll_and_rx_clock_config fields
  localparam int PLL_SKIP_BIT      = 7;
  localparam int ADC_HALF_BIT      = 5;
  localparam int ALT_TIMING_BIT    = 4;
  localparam int PLL_FIFTH_DIVIDER_BIT      = 3;
  localparam int PLL_MULT_LSB      = 0;
  // aux_clock_source_select fields
  localparam int DUPLEX_SEL_BIT    = 7;
  localparam int NARROW_SEL_BIT    = 6;
  localparam int AUX_SRC_BIT       = 5;
  localparam int STAT_TXRX_BIT     = 1;
  localparam int STAT_DUPLEX_BIT   = 0;

  // Writable masks and reset values
  localparam logic [7:0] MASK_IFACE_CLK_CTRL = 8'he6;
  localparam logic [7:0] MASK_TX_LATCH_INTERP = 8'h23;
  localparam logic [7:0] MASK_PLL_RX_CFG      = 8'hbf;
  localparam logic [7:0] MASK_AUX_SRC_SEL     = 8'he0;
  localparam logic [7:0] RST_CFG              = 8'h00;

  // Interpolation codes
  localparam logic [1:0] INTERP_X1 = 2'h0;
  localparam logic [1:0] INTERP_X2 = 2'h1;
  localparam logic [1:0] INTERP_X4 = 2'h2;
  // PLL multiplier codes
  localparam logic [2:0] MULT_X1  = 3'h0;
  localparam logic [2:0] MULT_X2  = 3'h1;
  localparam logic [2:0] MULT_X4  = 3'h2;
  localparam logic [2:0] MULT_X16 = 3'h4;

  // Base clock mode numbers
  localparam logic [3:0] MODE_FULL   = 4'h1;
  localparam logic [3:0] MODE_WIDE   = 4'h4;
  localparam logic [3:0] MODE_NARROW = 4'h7;

  // Divide-by-five terminal count
  localparam logic [2:0] DIV5_LAST = 3'h4;

  // Serial frame layout
  localparam logic [3:0] SPI_ADDR_LAST = 4'h7;
  localparam logic [3:0] SPI_DATA_LAST = 4'hf;

endpackage

//--- rtl/ccd_spi_port.sv
`timescale 1ns/1ps
module ccd_spi_port (
  input  wire logic       i_mclk,
  input  wire logic       i_resetn,
  input  wire logic       i_spi_clk,
  input  wire logic       i_spi_sel_n,
  input  wire logic       i_spi_din,
  output logic            o_spi_dout,
  output logic            o_spi_dout_oe,
  output logic            o_wr,
  output logic [6:0]      o_addr,
  output logic [7:0]      o_wdata,
  input  wire logic [7:0] i_rdata
);

  logic [2:0] meta;
  logic [2:0] pins;
  logic       clk_prev;
  logic [6:0] shreg;
  logic [3:0] bit_cnt;
  logic       rd_frame;
  logic       load_rd;
  logic [7:0] dout_sh;
  logic       clk_lvl;
  logic       sel_n;
  logic       din;
  logic       rise;
  logic       fall;

  assign clk_lvl = pins[2];
  assign sel_n   = pins[1];
  assign din     = pins[0];
  assign rise    = clk_lvl & ~clk_prev & ~sel_n;
  assign fall    = ~clk_lvl & clk_prev & ~sel_n;

  // Two-stage synchroniser for the port pins
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      meta     <= 3'h2;
      pins     <= 3'h2;
      clk_prev <= 1'b0;
    end
    else
    begin
      meta     <= {i_spi_clk, i_spi_sel_n, i_spi_din};
      pins     <= meta;
      clk_prev <= clk_lvl;
    end
  end

  // Frame capture: direction and address byte, then data byte
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      shreg    <= 7'h00;
      bit_cnt  <= 4'h0;
      rd_frame <= 1'b0;
      load_rd  <= 1'b0;
      o_addr   <= 7'h00;
      o_wdata  <= 8'h00;
      o_wr     <= 1'b0;
    end
    else
    begin
      o_wr    <= 1'b0;
      load_rd <= 1'b0;
      if (sel_n)
        bit_cnt <= 4'h0;
      else if (rise)
      begin
        shreg   <= {shreg[5:0], din};
        bit_cnt <= bit_cnt + 4'h1;
        if (bit_cnt == ccd_pkg::SPI_ADDR_LAST)
        begin
          rd_frame <= shreg[6];
          o_addr   <= {shreg[5:0], din};
          load_rd  <= shreg[6];
        end
        if (bit_cnt == ccd_pkg::SPI_DATA_LAST && !rd_frame)
        begin
          o_wdata <= {shreg, din};
          o_wr    <= 1'b1;
        end
      end
    end
  end

  // Read data shifts out on falling clock edges, MSB first
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      dout_sh       <= 8'h00;
      o_spi_dout    <= 1'b0;
      o_spi_dout_oe <= 1'b0;
    end
    else
    begin
      if (load_rd)
        dout_sh <= i_rdata;
      else if (fall && rd_frame && bit_cnt[3])
      begin
        o_spi_dout <= dout_sh[7];
        dout_sh    <= {dout_sh[6:0], 1'b0};
      end
      o_spi_dout_oe <= ~sel_n & rd_frame & bit_cnt[3];
    end
  end

endmodule

//--- rtl/ccd_clock_config.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Aux pin undriven when disabled, except full duplex
// - Aux enable drives clock; inverts in full duplex
// - Data clock pin inverted by invert bit
// - Transmit data latched on chosen clock edge
// - Interpolation one, two or four from field
// - Skip bit bypasses PLL for system clock
// - ADC clock optionally half receive rate
// - Receive clock from reference or PLL output
// - Optional divide-by-five on PLL output
// - PLL multiplier one to sixteen from code
// - Aux source is reference or PLL output
// - Transmit timing referenced to own output clock
// - Mode pins replace registers without serial port
// - Mode pins decode duplex, width, interpolation
// - Width pin ignored in full duplex
// - Clock mode field defaults to zero
// - Interleaved transmit clock twice non-interleaved rate at x2 and x4, same at x1
// - Half duplex transmit/receive pin is input
module ccd_clock_config (
  input  wire logic        i_mclk,
  input  wire logic        i_resetn,
  input  wire logic        i_spi_clk,
  input  wire logic        i_spi_sel_n,
  input  wire logic        i_spi_din,
  output logic             o_spi_dout,
  output logic             o_spi_dout_oe,
  input  wire logic        i_mode_pins_use,
  input  wire logic        i_duplex_select_pin,
  input  wire logic        i_interp_pin_high,
  input  wire logic        i_interp_pin_low,
  input  wire logic        i_ref_clock_in,
  input  wire logic        i_txrx_select_pin,
  output logic             o_txrx_select_pin,
  output logic             o_txrx_select_pin_oe,
  input  wire logic        i_aux_clock_pin,
  output logic             o_aux_clock_pin,
  output logic             o_aux_clock_pin_oe,
  output logic             o_data_clock_pin,
  input  wire logic [19:0] i_tx_data,
  output logic [19:0]      o_tx_word,
  output logic             o_tx_word_valid,
  output logic             o_dac_update,
  output logic             o_adc_clock_en,
  output logic [3:0]       o_clock_mode
);

  // Configuration registers
  logic [7:0]  interface_clock_output_control;
  logic [7:0]  transmit_latch_and_interpolation;
  logic [7:0]  pll_and_rx_clock_config;
  logic [7:0]  aux_clock_source_select;

  // Serial port wires
  logic        spi_wr;
  logic [6:0]  spi_addr;
  logic [7:0]  spi_wdata;
  logic [7:0]  spi_rdata;

  // Synchronised pins
  logic [25:0] pin_meta;
  logic [25:0] pin_sync;
  logic        use_pins;
  logic        duplex_select_pin;
  logic        interp_pin_high;
  logic        interp_pin_low;
  logic        ref_lvl;
  logic        txrx_select_pin;
  logic        width_select_pin;
  logic [19:0] tx_data_s;

  // Effective configuration
  logic        full_duplex;
  logic        half_duplex_narrow;
  logic [2:0]  clk_mode;
  logic        aux_clock_enable;
  logic        data_clock_invert;
  logic        tx_latch_edge;
  logic [1:0]  interp_code;
  logic        pll_skip;
  logic        adc_half;
  logic        alt_timing;
  logic        pll_fifth_divider;
  logic [2:0]  pll_mult;
  logic        aux_clock_source;
  logic [1:0]  pin_interp;
  logic        pin_interp_x1;

  // Clock generation state
  logic        ref_prev;
  logic        ref_edge;
  logic [15:0] ref_cnt;
  logic [15:0] ref_half;
  logic [15:0] pll_cnt;
  logic [15:0] pll_half;
  logic [15:0] pll_half_raw;
  logic [2:0]  mult_shift;
  logic        pll_tick;
  logic [2:0]  fifth_cnt;
  logic        pll_out_tick;
  logic        sys_tick;
  logic        rx_tick;
  logic        adc_phase;
  logic        adc_tick;
  logic        rx_clk;
  logic        pll_clk;
  logic        interleaved;
  logic [1:0]  tx_last;
  logic [1:0]  tx_cnt;
  logic        tx_toggle;
  logic        tx_clk;
  logic        tx_latch;
  logic        tx_sync;
  logic        transmitting;
  logic        aux_src_clk;

  // Serial configuration port
  ccd_spi_port u_spi (
    .i_mclk        (i_mclk),
    .i_resetn      (i_resetn),
    .i_spi_clk     (i_spi_clk),
    .i_spi_sel_n   (i_spi_sel_n),
    .i_spi_din     (i_spi_din),
    .o_spi_dout    (o_spi_dout),
    .o_spi_dout_oe (o_spi_dout_oe),
    .o_wr          (spi_wr),
    .o_addr        (spi_addr),
    .o_wdata       (spi_wdata),
    .i_rdata       (spi_rdata)
  );

  // Two-stage synchroniser for the mode, reference, transmit/receive and data pins
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      pin_meta <= 26'h0000000;
      pin_sync <= 26'h0000000;
    end
    else
    begin
      pin_meta <= {i_mode_pins_use, i_duplex_select_pin,
                   i_interp_pin_high, i_interp_pin_low,
                   i_ref_clock_in, i_txrx_select_pin, i_tx_data};
      pin_sync <= pin_meta;
    end
  end

  assign use_pins           = pin_sync[25];
  assign duplex_select_pin  = pin_sync[24];
  assign interp_pin_high    = pin_sync[23];
  assign interp_pin_low     = pin_sync[22];
  assign ref_lvl            = pin_sync[21];
  assign txrx_select_pin    = pin_sync[20];
  assign tx_data_s          = pin_sync[19:0];

  // Width select shares the aux pin, sampled every cycle, used only while it is an input
  logic [1:0] width_sync;
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
      width_sync <= 2'h0;
    else
      width_sync <= {width_sync[0], i_aux_clock_pin};
  end
  assign width_select_pin = width_sync[1];

  // Register writes keep only the defined bits; reset to zero
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      interface_clock_output_control   <= ccd_pkg::RST_CFG;
      transmit_latch_and_interpolation <= ccd_pkg::RST_CFG;
      pll_and_rx_clock_config          <= ccd_pkg::RST_CFG;
      aux_clock_source_select          <= ccd_pkg::RST_CFG;
    end
    else if (spi_wr)
    begin
      unique case (spi_addr)
        ccd_pkg::OFS_IFACE_CLK_CTRL:
          interface_clock_output_control <=
            spi_wdata & ccd_pkg::MASK_IFACE_CLK_CTRL;
        ccd_pkg::OFS_TX_LATCH_INTERP:
          transmit_latch_and_interpolation <=
            spi_wdata & ccd_pkg::MASK_TX_LATCH_INTERP;
        ccd_pkg::OFS_PLL_RX_CFG:
          pll_and_rx_clock_config <=
            spi_wdata & ccd_pkg::MASK_PLL_RX_CFG;
        ccd_pkg::OFS_AUX_SRC_SEL:
          aux_clock_source_select <=
            spi_wdata & ccd_pkg::MASK_AUX_SRC_SEL;
        default:
          ;
      endcase
    end
  end

  // Read-back mux; unmapped addresses read zero
  assign spi_rdata =
    (spi_addr == ccd_pkg::OFS_IFACE_CLK_CTRL)  ?
      interface_clock_output_control :
    (spi_addr == ccd_pkg::OFS_TX_LATCH_INTERP) ?
      transmit_latch_and_interpolation :
    (spi_addr == ccd_pkg::OFS_PLL_RX_CFG)      ? pll_and_rx_clock_config :
    (spi_addr == ccd_pkg::OFS_AUX_SRC_SEL)     ?
      (aux_clock_source_select
       | ({7'h00, transmitting} << ccd_pkg::STAT_TXRX_BIT)
       | ({7'h00, full_duplex} << ccd_pkg::STAT_DUPLEX_BIT)) :
    8'h00;

  // Mode pin interpolation decode: 01 x2, 10 x4, 00 x1 bypassed
  assign pin_interp    = {interp_pin_high, interp_pin_low};
  assign pin_interp_x1 = (pin_interp == 2'h0);

  // Effective configuration from mode pins or registers
  assign full_duplex = use_pins ? duplex_select_pin
    : aux_clock_source_select[ccd_pkg::DUPLEX_SEL_BIT];
  assign half_duplex_narrow = full_duplex ? 1'b0
    : use_pins ? width_select_pin
    : aux_clock_source_select[ccd_pkg::NARROW_SEL_BIT];
  assign clk_mode = use_pins ? 3'h0
    : interface_clock_output_control[ccd_pkg::CLK_MODE_LSB +: 3];
  assign aux_clock_enable = ~use_pins
    & interface_clock_output_control[ccd_pkg::AUX_EN_BIT];
  assign data_clock_invert = ~use_pins
    & interface_clock_output_control[ccd_pkg::DATA_INV_BIT];
  assign tx_latch_edge = ~use_pins
    & transmit_latch_and_interpolation[ccd_pkg::TX_EDGE_BIT];
  assign interp_code = use_pins
    ? (pin_interp_x1 ? ccd_pkg::INTERP_X1
       : interp_pin_high ? ccd_pkg::INTERP_X4 : ccd_pkg::INTERP_X2)
    : transmit_latch_and_interpolation[ccd_pkg::INTERP_LSB +: 2];
  assign pll_skip = use_pins ? pin_interp_x1
    : pll_and_rx_clock_config[ccd_pkg::PLL_SKIP_BIT];
  assign pll_mult = use_pins
    ? (pin_interp_x1 ? ccd_pkg::MULT_X1
       : interp_pin_high ? ccd_pkg::MULT_X4 : ccd_pkg::MULT_X2)
    : pll_and_rx_clock_config[ccd_pkg::PLL_MULT_LSB +: 3];
  assign adc_half = ~use_pins
    & pll_and_rx_clock_config[ccd_pkg::ADC_HALF_BIT];
  assign alt_timing = ~use_pins
    & pll_and_rx_clock_config[ccd_pkg::ALT_TIMING_BIT];
  assign pll_fifth_divider = ~use_pins
    & pll_and_rx_clock_config[ccd_pkg::PLL_FIFTH_DIVIDER_BIT];
  assign aux_clock_source = ~use_pins
    & aux_clock_source_select[ccd_pkg::AUX_SRC_BIT];

  // Reported clock mode: base mode plus one when the clock mode field is nonzero
  assign o_clock_mode =
    (full_duplex ? ccd_pkg::MODE_FULL
     : half_duplex_narrow ? ccd_pkg::MODE_NARROW : ccd_pkg::MODE_WIDE)
    + {3'h0, (clk_mode != 3'h0)};

  // Reference edges (both) measured to model the PLL period
  assign ref_edge = ref_lvl ^ ref_prev;
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ref_prev <= 1'b0;
      ref_cnt  <= 16'h0000;
      ref_half <= 16'h0001;
    end
    else
    begin
      ref_prev <= ref_lvl;
      if (ref_edge)
      begin
        ref_cnt  <= 16'h0000;
        ref_half <= ref_cnt + 16'h0001;
      end
      else if (ref_cnt != 16'hffff)
        ref_cnt <= ref_cnt + 16'h0001;
    end
  end

  // Multiplier code to shift; reserved codes act as x1
  assign mult_shift = (pll_mult <= ccd_pkg::MULT_X16)
    ? pll_mult : 3'h0;
  assign pll_half_raw = ref_half >> mult_shift;
  assign pll_half = (pll_half_raw == 16'h0000) ? 16'h0001 : pll_half_raw;
  assign pll_tick = ref_edge | (pll_cnt == pll_half - 16'h0001);

  // PLL half-period counter, realigned on every reference edge
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
      pll_cnt <= 16'h0000;
    else if (pll_tick)
      pll_cnt <= 16'h0000;
    else
      pll_cnt <= pll_cnt + 16'h0001;
  end

  // Optional divide-by-five on the PLL output
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
      fifth_cnt <= 3'h0;
    else if (pll_tick)
      fifth_cnt <= (fifth_cnt == ccd_pkg::DIV5_LAST) ? 3'h0
                   : fifth_cnt + 3'h1;
  end
  assign pll_out_tick = pll_fifth_divider
    ? (pll_tick & (fifth_cnt == ccd_pkg::DIV5_LAST))
    : pll_tick;

  // System, receive and ADC clock selection
  assign sys_tick = pll_skip ? ref_edge : pll_out_tick;
  assign rx_tick  = alt_timing ? sys_tick : ref_edge;
  assign adc_tick = adc_half ? (rx_tick & adc_phase) : rx_tick;
  assign o_dac_update   = sys_tick;
  assign o_adc_clock_en = adc_tick;

  // Transmit clock divide: interleaved runs twice the other rate at x2 and x4, the same at x1
  assign interleaved = full_duplex | half_duplex_narrow;
  assign tx_last =
    (interp_code == ccd_pkg::INTERP_X4) ? (interleaved ? 2'h1 : 2'h3) :
    (interp_code == ccd_pkg::INTERP_X2) ? (interleaved ? 2'h0 : 2'h1) :
    2'h0;
  assign tx_toggle = sys_tick & (tx_cnt == tx_last);
  assign tx_latch  = tx_toggle & (tx_clk == tx_latch_edge);

  // Clock waveforms and transmit counter
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      adc_phase <= 1'b0;
      rx_clk    <= 1'b0;
      pll_clk   <= 1'b0;
      tx_cnt    <= 2'h0;
      tx_clk    <= 1'b0;
    end
    else
    begin
      if (rx_tick)
        adc_phase <= ~adc_phase;
      if (adc_tick)
        rx_clk <= ~rx_clk;
      if (sys_tick)
        pll_clk <= ~pll_clk;
      if (sys_tick)
        tx_cnt <= (tx_cnt == tx_last) ? 2'h0 : tx_cnt + 2'h1;
      if (tx_toggle)
        tx_clk <= ~tx_clk;
    end
  end

  // Transmit data capture on the chosen edge of the own clock
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_tx_word       <= 20'h00000;
      o_tx_word_valid <= 1'b0;
      tx_sync         <= 1'b0;
    end
    else
    begin
      o_tx_word_valid <= tx_latch & transmitting;
      if (tx_latch && transmitting)
      begin
        o_tx_word <= tx_data_s;
        tx_sync   <= ~tx_sync;
      end
    end
  end

  // Half duplex: transmit/receive pin is an input, high for transmit
  assign transmitting = full_duplex | txrx_select_pin;
  assign o_txrx_select_pin    = full_duplex & tx_sync;
  assign o_txrx_select_pin_oe = full_duplex;

  // Data clock pin: transmit or receive clock, optionally inverted
  assign o_data_clock_pin = (transmitting ? tx_clk : rx_clk)
    ^ data_clock_invert;

  // Aux pin: reference or PLL clock; always driven in full duplex
  assign aux_src_clk = aux_clock_source ? pll_clk : ref_lvl;
  assign o_aux_clock_pin = full_duplex
    ? (aux_src_clk ^ aux_clock_enable)
    : (aux_clock_enable & aux_src_clk);
  assign o_aux_clock_pin_oe = full_duplex | aux_clock_enable;

endmodule

//--- test/ccd_clock_config_props.sv
`timescale 1ns/1ps
module ccd_clock_config_props (
  input wire logic       i_mclk,
  input wire logic       i_resetn,
  input wire logic       i_mode_pins_use,
  input wire logic       i_duplex_select_pin,
  input wire logic       i_aux_clock_pin,
  input wire logic       o_txrx_select_pin_oe,
  input wire logic       o_aux_clock_pin_oe,
  input wire logic       o_tx_word_valid,
  input wire logic [3:0] o_clock_mode
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  // Mode pins held long enough to pass the synchronisers
  sequence pins_full_s;
    (i_mode_pins_use && i_duplex_select_pin) [*6];
  endsequence
  sequence pins_wide_s;
    (i_mode_pins_use && !i_duplex_select_pin && !i_aux_clock_pin) [*6];
  endsequence
  sequence pins_narrow_s;
    (i_mode_pins_use && !i_duplex_select_pin && i_aux_clock_pin) [*6];
  endsequence

  a_full_aux_drive: assert property (
    o_txrx_select_pin_oe |-> o_aux_clock_pin_oe)
    else $error("aux pin not driven in full duplex");
  a_full_mode_num: assert property (o_txrx_select_pin_oe [*4] |->
    $past(o_clock_mode, 2) inside {4'h1, 4'h2})
    else $error("full duplex clock mode wrong");
  a_hd_mode_num: assert property (!o_txrx_select_pin_oe [*4] |->
    $past(o_clock_mode, 2) inside {4'h4, 4'h5, 4'h7, 4'h8})
    else $error("half duplex clock mode wrong");
  a_rst_quiet: assert property ($rose(i_resetn) |->
    !o_aux_clock_pin_oe && !o_txrx_select_pin_oe)
    else $error("pins driven after reset");
  a_valid_pulse: assert property (o_tx_word_valid |=> !o_tx_word_valid)
    else $error("word valid longer than one cycle");
  a_pins_full_mode: assert property (pins_full_s |->
    o_txrx_select_pin_oe && o_clock_mode == 4'h1)
    else $error("mode pins full duplex not applied");
  a_pins_wide_mode: assert property (pins_wide_s |->
    !o_txrx_select_pin_oe && o_clock_mode == 4'h4)
    else $error("mode pins wide half duplex not applied");
  a_pins_narrow_mode: assert property (pins_narrow_s |->
    !o_txrx_select_pin_oe && o_clock_mode == 4'h7)
    else $error("mode pins narrow half duplex not applied");
endmodule

bind ccd_clock_config ccd_clock_config_props u_props (
  .i_mclk              (i_mclk),
  .i_resetn            (i_resetn),
  .i_mode_pins_use     (i_mode_pins_use),
  .i_duplex_select_pin (i_duplex_select_pin),
  .i_aux_clock_pin     (i_aux_clock_pin),
  .o_txrx_select_pin_oe(o_txrx_select_pin_oe),
  .o_aux_clock_pin_oe  (o_aux_clock_pin_oe),
  .o_tx_word_valid     (o_tx_word_valid),
  .o_clock_mode        (o_clock_mode)
);

//--- test/ccd_dsp_model.sv
`timescale 1ns/1ps
module ccd_dsp_model (
  input  wire logic   i_mclk,
  input  wire logic   i_data_clk,
  input  wire logic   i_tx_on,
  input  wire logic   i_edge,
  output logic [19:0] o_tx_data,
  output logic        o_txrx
);
  logic [9:0] cnt;
  logic       prev;

  initial
  begin
    cnt = 10'h000;
    prev = 1'b0;
    o_tx_data = 20'h00000;
  end

  // Half duplex direction request
  assign o_txrx = i_tx_on;

  // New word at the non-latching edge so it is steady at the latching one;
  // a released bus shows a changing pattern instead of the last word
  always @(posedge i_mclk)
  begin
    prev <= i_data_clk;
    if (!i_tx_on)
      o_tx_data <= ~o_tx_data;
    else if (prev !== i_data_clk && i_data_clk === i_edge)
    begin
      cnt <= cnt + 10'h001;
      o_tx_data <= {cnt, ~cnt};
    end
  end
endmodule

//--- test/ccd_clock_config_tb_top.sv
`timescale 1ns/1ps
module ccd_clock_config_tb_top;
  logic        clk, rstn, sclk, sel_n, din, pins, dup, ip_hi, ip_lo;
  logic        ref_clk, ref_on, width, tx_on, edge_sel;
  logic [3:0]  rdiv;
  logic [7:0]  q;
  logic [19:0] tx_data, tx_word;
  logic [3:0]  mode;
  logic        spi_dout, spi_oe, txrx_out, txrx_oe, aux_out, aux_oe;
  logic        dclk, tx_valid, dac, adc, dsp_txrx;
  int          n_errors, n_compared, nd, na, nv, nx, ns;
  wire         txrx_w = txrx_oe ? txrx_out : dsp_txrx;
  wire         aux_w = aux_oe ? aux_out : width;

  ccd_clock_config dut (.i_mclk(clk), .i_resetn(rstn), .i_spi_clk(sclk),
    .i_spi_sel_n(sel_n), .i_spi_din(din), .o_spi_dout(spi_dout),
    .o_spi_dout_oe(spi_oe), .i_mode_pins_use(pins),
    .i_duplex_select_pin(dup), .i_interp_pin_high(ip_hi),
    .i_interp_pin_low(ip_lo), .i_ref_clock_in(ref_clk),
    .i_txrx_select_pin(txrx_w), .o_txrx_select_pin(txrx_out),
    .o_txrx_select_pin_oe(txrx_oe), .i_aux_clock_pin(aux_w),
    .o_aux_clock_pin(aux_out), .o_aux_clock_pin_oe(aux_oe),
    .o_data_clock_pin(dclk), .i_tx_data(tx_data), .o_tx_word(tx_word),
    .o_tx_word_valid(tx_valid), .o_dac_update(dac),
    .o_adc_clock_en(adc), .o_clock_mode(mode));
  ccd_dsp_model u_dsp (.i_mclk(clk), .i_data_clk(dclk), .i_tx_on(tx_on),
    .i_edge(edge_sel), .o_tx_data(tx_data), .o_txrx(dsp_txrx));

  // Clock and a reference input toggling every 16 cycles
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (ref_on)
    begin
      rdiv <= rdiv + 4'h1;
      if (rdiv == 4'hf)
        ref_clk <= ~ref_clk;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic near(input int g, input int e, input int t);
    chk((g > e + t || g + t < e) ? g : e, e);
  endtask

  // One serial frame, MSB first, clock low for 5 cycles and high for 4
  task automatic spi(input logic rd, input logic [6:0] a, input logic [7:0] d);
    logic [15:0] f;
    f = {rd, a, d};
    sel_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 15; i >= 0; i--)
    begin
      din <= f[i];
      sclk <= 1'b0;
      repeat (4) @(posedge clk);
      #1 if (i < 8) q[i] = spi_dout;
      chk(spi_oe, rd && i < 8);
      @(posedge clk);
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
    end
    sclk <= 1'b0;
    repeat (6) @(posedge clk);
    sel_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    spi(1'b0, a, d);
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
    spi(1'b1, a, 8'h00);
    chk(q, e);
  endtask

  // Counts system, ADC, word and aux-pin events over n cycles
  task automatic measure(input int n);
    logic p, s;
    nd = 0; na = 0; nv = 0; nx = 0;
    ns = 0;
    repeat (100) @(posedge clk);
    p = aux_out;
    s = txrx_out;
    repeat (n)
    begin
      @(negedge clk);
      nd += int'(dac === 1'b1);
      na += int'(adc === 1'b1);
      nv += int'(tx_valid === 1'b1);
      nx += int'(aux_out !== p);
      p = aux_out;
      ns += int'(txrx_out !== s);
      s = txrx_out;
      if (tx_valid === 1'b1)
        chk(tx_word[19:10] ^ tx_word[9:0], 10'h3ff);
    end
  endtask

  task automatic t_regs;
    logic [6:0] a[5] = '{7'h01, 7'h13, 7'h15, 7'h16, 7'h7f};
    logic [7:0] m[5] = '{8'he6, 8'h23, 8'hbf, 8'he3, 8'h00};
    for (int i = 0; i < 5; i++)
    begin
      rdchk(a[i], 8'h00);
      wr(a[i], 8'hff);
      rdchk(a[i], m[i]);
      wr(a[i], 8'h00);
    end
    $display("test registers done");
  endtask

  task automatic t_rates;
    logic [7:0] r[10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h82,
                          8'h0c, 8'h32, 8'h20};
    int         d[10] = '{40, 80, 160, 320, 640, 40, 40, 128, 160, 40};
    int         c[10] = '{40, 40, 40, 40, 40, 40, 40, 40, 80, 20};
    for (int i = 0; i < 10; i++)
    begin
      wr(7'h15, r[i]);
      measure(640);
      near(nd, d[i], 4);
      near(na, c[i], 4);
    end
    wr(7'h15, 8'h00);
    $display("test clock rates done");
  endtask

  task automatic t_tx;
    logic [7:0] r[4] = '{8'h00, 8'h01, 8'h02, 8'h21};
    int         e[4] = '{20, 10, 5, 10};
    tx_on <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      edge_sel <= r[i][5];
      wr(7'h13, r[i]);
      measure(640);
      near(nv, e[i], 1);
    end
    tx_on <= 1'b0;
    edge_sel <= 1'b0;
    wr(7'h13, 8'h00);
    $display("test transmit latch done");
  endtask

  task automatic t_aux;
    logic a, d;
    measure(64);
    chk(aux_oe, 1'b0);
    chk(nx, 0);
    wr(7'h01, 8'h04);
    measure(64);
    chk(aux_oe, 1'b1);
    near(nx, 4, 1);
    wr(7'h15, 8'h02);
    wr(7'h16, 8'h20);
    measure(64);
    near(nx, 16, 2);
    wr(7'h15, 8'h80);
    wr(7'h16, 8'h80);
    wr(7'h01, 8'h00);
    chk(aux_oe, 1'b1);
    ref_on <= 1'b0;
    repeat (40) @(posedge clk);
    a = aux_out;
    d = dclk;
    wr(7'h01, 8'h06);
    chk(aux_out, !a);
    chk(dclk, !d);
    ref_on <= 1'b1;
    wr(7'h01, 8'h00);
    wr(7'h16, 8'h00);
    wr(7'h15, 8'h00);
    $display("test aux and data clock pins done");
  endtask

  task automatic t_pins;
    pins <= 1'b1;
    dup <= 1'b1;
    width <= 1'b1;
    ip_lo <= 1'b1;
    repeat (20) @(posedge clk);
    chk(mode, 4'h1);
    chk(txrx_oe, 1'b1);
    tx_on <= 1'b1;
    measure(640);
    near(nv, 40, 1);
    chk(ns, nv);
    tx_on <= 1'b0;
    dup <= 1'b0;
    for (int w = 0; w < 2; w++)
    begin
      width <= w[0];
      repeat (20) @(posedge clk);
      chk(mode, w[0] ? 4'h7 : 4'h4);
    end
    width <= 1'b0;
    measure(640);
    near(nd, 80, 4);
    ip_lo <= 1'b0;
    measure(640);
    near(nd, 40, 4);
    ip_hi <= 1'b1;
    measure(640);
    near(nd, 160, 4);
    pins <= 1'b0;
    $display("test mode pins done");
  endtask

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    {rstn, sclk, din, pins, dup, ip_hi, ip_lo, width, tx_on} = '0;
    {ref_clk, edge_sel} = '0;
    {sel_n, ref_on} = 2'b11;
    rdiv = 4'h0;
    n_errors = 0;
    n_compared = 0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (10) @(posedge clk);
    t_regs;
    t_rates;
    t_tx;
    t_aux;
    t_pins;
    finish_test;
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (90000) @(posedge clk);
    n_errors++;
    finish_test;
  end
endmodule
